// ==== shared/commut_pkg.sv ====
package commut_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEAD_TIME_NS = 500;
  localparam int BLANK_TIME_NS = 1000;
  localparam int OFF_TIME_NS = 25000;
  localparam int OC_HOLD_NS = 100000;
  // Least times round up to whole cycles
  localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYC = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CYC = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_HOLD_CYC = (OC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  // ****************************************************************
  // Hall codes, order {hall_in_1, hall_in_2, hall_in_3}
  // ****************************************************************
  localparam logic [2:0] HALL_HLL = 3'h4;
  localparam logic [2:0] HALL_HHL = 3'h6;
  localparam logic [2:0] HALL_LHL = 3'h2;
  localparam logic [2:0] HALL_HHH = 3'h7;
  localparam logic [2:0] HALL_LHH = 3'h3;
  localparam logic [2:0] HALL_LLH = 3'h1;
  localparam logic [2:0] HALL_HLH = 3'h5;
  localparam logic [2:0] HALL_LLL = 3'h0;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ROLE_FLOAT, ROLE_HIGH, ROLE_PWM} role_e;
  typedef enum logic {CHOP_ON, CHOP_OFF} chop_e;
endpackage : commut_pkg

// ==== shared/leg_if.sv ====
interface leg_if;
  logic want_hs;
  logic want_ls;
  logic hs;
  logic ls;
  logic busy;
  modport leg (input want_hs, input want_ls, output hs, output ls, output busy);
  modport ctrl (output want_hs, output want_ls, input hs, input ls, input busy);
endinterface : leg_if

// ==== src/phase_leg.sv ====
module phase_leg
  import commut_pkg::*;
#(
  parameter int DEAD = DEAD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  leg_if.leg bus
);
  logic [CNT_W-1:0] dead_cnt;
  logic hs_q;
  logic ls_q;
  wire any_now = hs_q | ls_q;
  wire any_want = bus.want_hs | bus.want_ls;
  wire differ = (hs_q != bus.want_hs) || (ls_q != bus.want_ls);
  // Switching between two driven states passes through both-off
  wire need_dead = differ && any_now && any_want;
  wire counting = dead_cnt != '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      dead_cnt <= '0;
    end else if (!any_want) begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      dead_cnt <= '0;
    end else if (need_dead) begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      dead_cnt <= CNT_W'(DEAD);
    end else if (counting) begin
      dead_cnt <= dead_cnt - 1'b1;
    end else begin
      hs_q <= bus.want_hs;
      ls_q <= bus.want_ls;
    end
  end

  assign bus.hs = hs_q;
  assign bus.ls = ls_q;
  assign bus.busy = counting;

  no_shoot_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(hs_q && ls_q) && !($past(hs_q) && ls_q) && !($past(ls_q) && hs_q))
    else $error("Leg switched without dead time");
endmodule : phase_leg

// ==== src/hall_six_step_commutator.sv ====
// Overview of operation
// - Over-temperature drives the active-low fault flag low.
// - Overcurrent on any half-bridge drives the fault flag low.
// - Forward decode of the four codes shared by both sensor placements.
// - 120-degree codes LHL and HLH decoded in forward direction.
// - 60-degree codes HHH and LLL copy LHL and HLH patterns.
// - Backward swaps high-side and PWM roles; floating phase unchanged.
// - Current limited by PWM with fixed off time on the PWM phase.
// - Brake low turns on all three high sides, overriding decode.
// - Overcurrent still disables bridges and flags fault while braking.
// - Dead time with both transistors off when a leg switches directly between two driven states.
// - Sense comparator ignored for a blanking time after dead time.
module hall_six_step_commutator
  import commut_pkg::*;
#(
  parameter int OFF_TIME = OFF_CYC,
  parameter int BLANK = BLANK_CYC,
  parameter int OC_HOLD = OC_HOLD_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HALL_IN_1,
  input wire logic HALL_IN_2,
  input wire logic HALL_IN_3,
  input wire logic ROTATION_DIRECTION,
  input wire logic BRAKE_N,
  input wire logic SENSE_TRIP,
  input wire logic [2:0] OVERCURRENT,
  input wire logic OVER_TEMP,
  output logic [2:0] HIGH_SIDE_ON,
  output logic [2:0] LOW_SIDE_ON,
  output logic FAULT_FLAG_N
);
  localparam int BRAKE_MAX = DEAD_CYC + 3;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [9:0] sync_meta;
  logic [9:0] sync_q;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync_meta <= 10'h300;
      sync_q <= 10'h300;
    end else begin
      sync_meta <= {ROTATION_DIRECTION, BRAKE_N, OVER_TEMP, OVERCURRENT, SENSE_TRIP,
                    HALL_IN_1, HALL_IN_2, HALL_IN_3};
      sync_q <= sync_meta;
    end
  end
  wire [2:0] hall_code = sync_q[2:0];
  wire sense_s = sync_q[3];
  wire [2:0] oc_s = sync_q[6:4];
  wire temp_s = sync_q[7];
  wire brake_n_s = sync_q[8];
  // Direction can be chopped by the controller for voltage mode
  // swapping roles each edge applies the mean phase voltage.
  logic fwd_s;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fwd_s <= 1'b1;
    end else begin
      fwd_s <= sync_q[9];
    end
  end

  // ****************************************************************
  // Hall decode
  // ****************************************************************
  role_e fwd_role [3];
  role_e role [3];
  always_comb begin
    fwd_role[0] = ROLE_FLOAT;
    fwd_role[1] = ROLE_FLOAT;
    fwd_role[2] = ROLE_FLOAT;
    unique case (hall_code)
      HALL_HLL: begin
        fwd_role[0] = ROLE_HIGH;
        fwd_role[2] = ROLE_PWM;
      end
      HALL_HHL: begin
        fwd_role[1] = ROLE_HIGH;
        fwd_role[2] = ROLE_PWM;
      end
      HALL_LHL, HALL_HHH: begin
        fwd_role[0] = ROLE_PWM;
        fwd_role[1] = ROLE_HIGH;
      end
      HALL_LHH: begin
        fwd_role[0] = ROLE_PWM;
        fwd_role[2] = ROLE_HIGH;
      end
      HALL_LLH: begin
        fwd_role[1] = ROLE_PWM;
        fwd_role[2] = ROLE_HIGH;
      end
      HALL_HLH, HALL_LLL: begin
        fwd_role[0] = ROLE_HIGH;
        fwd_role[1] = ROLE_PWM;
      end
    endcase
  end
  for (genvar p = 0; p < 3; p++) begin : g_dir
    assign role[p] = fwd_s ? fwd_role[p] :
                     (fwd_role[p] == ROLE_HIGH) ? ROLE_PWM :
                     (fwd_role[p] == ROLE_PWM) ? ROLE_HIGH : ROLE_FLOAT;
  end

  // ****************************************************************
  // Protection
  // ****************************************************************
  // The hold keeps the bridge off long enough for the load current to
  // decay, avoiding a build-up from repeated overcurrent events.
  logic [CNT_W-1:0] oc_hold;
  logic tripped;
  wire oc_any = |oc_s;
  wire next_tripped = temp_s || oc_any || (oc_hold != '0);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      oc_hold <= '0;
      tripped <= 1'b0;
      FAULT_FLAG_N <= 1'b1;
    end else begin
      oc_hold <= oc_any ? CNT_W'(OC_HOLD) : (oc_hold != '0) ? oc_hold - 1'b1 : '0;
      tripped <= next_tripped;
      FAULT_FLAG_N <= !(temp_s || oc_any);
    end
  end

  // ****************************************************************
  // Current chopper
  // ****************************************************************
  leg_if lg [3] ();
  wire [2:0] leg_busy = {lg[2].busy, lg[1].busy, lg[0].busy};
  chop_e chop;
  logic [CNT_W-1:0] off_cnt;
  logic [CNT_W-1:0] blank_cnt;
  // Comparator is blind while a leg is dead and for the blanking after
  wire sense_ok = sense_s && (leg_busy == 3'h0) && (blank_cnt == '0);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      chop <= CHOP_ON;
      off_cnt <= '0;
      blank_cnt <= CNT_W'(BLANK);
    end else begin
      unique case (chop)
        CHOP_ON: begin
          if (leg_busy != 3'h0) begin
            blank_cnt <= CNT_W'(BLANK);
          end else if (blank_cnt != '0) begin
            blank_cnt <= blank_cnt - 1'b1;
          end
          if (sense_ok) begin
            chop <= CHOP_OFF;
            off_cnt <= CNT_W'(OFF_TIME - 1);
          end
        end
        CHOP_OFF: begin
          blank_cnt <= CNT_W'(BLANK);
          if (off_cnt == '0) begin
            chop <= CHOP_ON;
          end else begin
            off_cnt <= off_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Bridge legs
  // ****************************************************************
  // Off time recirculates on the high sides (slow decay)
  for (genvar p = 0; p < 3; p++) begin : g_leg
    wire drive_hs = (role[p] == ROLE_HIGH) || (role[p] == ROLE_PWM && chop == CHOP_OFF);
    wire drive_ls = (role[p] == ROLE_PWM) && (chop == CHOP_ON);
    assign lg[p].want_hs = !tripped && (!brake_n_s || drive_hs);
    assign lg[p].want_ls = !tripped && brake_n_s && drive_ls;
    assign HIGH_SIDE_ON[p] = lg[p].hs;
    assign LOW_SIDE_ON[p] = lg[p].ls;
    phase_leg #(.DEAD(DEAD_CYC)) u_leg (
      .clk(CLK),
      .rst_n(RST_N),
      .bus(lg[p])
    );
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  temp_flag_a: assert property (temp_s |=> !FAULT_FLAG_N)
    else $error("Over-temperature did not flag fault");
  oc_flag_a: assert property (oc_any |=> !FAULT_FLAG_N)
    else $error("Overcurrent did not flag fault");
  brake_oc_off_a: assert property (!brake_n_s && oc_any |-> ##2
    (HIGH_SIDE_ON == 3'h0 && LOW_SIDE_ON == 3'h0))
    else $error("Bridges not disabled by overcurrent in brake");
  fwd_decode_a: assert property (fwd_s && hall_code == HALL_HLL |->
    role[0] == ROLE_HIGH && role[1] == ROLE_FLOAT && role[2] == ROLE_PWM)
    else $error("Forward decode wrong");
  code120_a: assert property (fwd_s && hall_code == HALL_HLH |->
    role[0] == ROLE_HIGH && role[1] == ROLE_PWM && role[2] == ROLE_FLOAT)
    else $error("120 degree decode wrong");
  code60_a: assert property (hall_code == HALL_HHH |->
    role[0] == (fwd_s ? ROLE_PWM : ROLE_HIGH) && role[2] == ROLE_FLOAT)
    else $error("60 degree decode wrong");
  back_swap_a: assert property (!fwd_s && hall_code == HALL_LLH |->
    role[0] == ROLE_FLOAT && role[1] == ROLE_HIGH && role[2] == ROLE_PWM)
    else $error("Backward swap wrong");
  off_end_a: assert property (chop == CHOP_OFF && off_cnt == '0 |=> chop == CHOP_ON)
    else $error("Off time not ended");
  off_hold_a: assert property (chop == CHOP_OFF && off_cnt != '0 |=> chop == CHOP_OFF)
    else $error("Off time cut short");
  blank_hold_a: assert property (chop == CHOP_ON && blank_cnt != '0 |=> chop == CHOP_ON)
    else $error("Sense acted during blanking");
  brake_on_a: assert property ((!brake_n_s && !next_tripped) [*3] |->
    ##[0:BRAKE_MAX] (HIGH_SIDE_ON == 3'h7 || tripped))
    else $error("Brake did not turn on high sides");

  brake_c: cover property (!brake_n_s ##1 HIGH_SIDE_ON == 3'h7);
  chop_c: cover property (chop == CHOP_ON ##1 chop == CHOP_OFF);
  fault_c: cover property ($fell(FAULT_FLAG_N));
  back_c: cover property (!fwd_s && LOW_SIDE_ON != 3'h0);
endmodule : hall_six_step_commutator

// ==== verif/motor_side_model.sv ====
module motor_side_model
  import commut_pkg::*;
(
  input wire logic clk,
  input wire logic [2:0] code,
  input wire logic fwd,
  input wire logic brk_n,
  input wire logic chop_en,
  input wire logic amp_en,
  input wire logic [2:0] oc,
  input wire logic ot,
  input wire logic [2:0] low_on,
  output logic [2:0] hall = 3'h4,
  output logic dir = 1'b1,
  output logic brake_n = 1'b1,
  output logic trip = 1'b0,
  output logic [2:0] overcurrent = 3'h0,
  output logic over_temp = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] ph = 5'h00;
  logic [4:0] cur = 5'h00;
  logic [2:0] low_q = 3'h0;
  // ****************************************************************
  // Sensors, host levels and a crude winding current
  // ****************************************************************
  always @(posedge clk) begin
    ph <= ph + 5'h01;
    low_q <= low_on;
    hall <= code;
    brake_n <= brk_n;
    overcurrent <= oc;
    over_temp <= ot;
    // Half duty, slow enough for the legs to settle each half
    dir <= chop_en ? ph[4] : fwd;
    if (|low_on) cur <= cur + 5'h01;
    else if (cur != 5'h00) cur <= cur - 5'h01;
    // A spike at each on-time start must not end the on time
    trip <= amp_en && ((|(low_on & ~low_q)) || cur > 5'h0c);
  end
endmodule : motor_side_model

// ==== verif/tb_top.sv ====
module tb_top;
  import commut_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OFF_T = 20;
  localparam int BLK = 6;
  localparam int HOLD = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] code = 3'h4;
  logic fwd = 1'b1, brk_n = 1'b1, chop_en = 1'b0, amp_en = 1'b0, ot = 1'b0;
  logic [2:0] oc = 3'h0;
  logic [2:0] hall, ovc, hs, ls;
  logic dir, brake_n, trip, otmp, flag_n;
  logic [2:0] hs_q = 3'h0, ls_q = 3'h0;
  logic [1:0] arm = 2'h0;
  logic seen_f = 1'b0, seen_b = 1'b0;
  logic [31:0] lf = 32'hdf2d;
  int error_cnt = 0, tests_run = 0, xc = 0, run_hs = 0, run_ls = 0;
  int min_off = 999, min_on = 999, rises = 0;
  always #50 clk = ~clk;
  hall_six_step_commutator #(.OFF_TIME(OFF_T), .BLANK(BLK), .OC_HOLD(HOLD)) i_dut (
    .CLK(clk), .RST_N(rst_n), .HALL_IN_1(hall[2]), .HALL_IN_2(hall[1]), .HALL_IN_3(hall[0]),
    .ROTATION_DIRECTION(dir), .BRAKE_N(brake_n), .SENSE_TRIP(trip), .OVERCURRENT(ovc),
    .OVER_TEMP(otmp), .HIGH_SIDE_ON(hs), .LOW_SIDE_ON(ls), .FAULT_FLAG_N(flag_n));
  motor_side_model i_host (.clk(clk), .code(code), .fwd(fwd), .brk_n(brk_n),
    .chop_en(chop_en), .amp_en(amp_en), .oc(oc), .ot(ot), .low_on(ls), .hall(hall),
    .dir(dir), .brake_n(brake_n), .trip(trip), .overcurrent(ovc), .over_temp(otmp));
  // ****************************************************************
  // Monitor: shoot-through, chopper run lengths, patterns seen
  // ****************************************************************
  always @(posedge clk) begin
    hs_q <= hs;
    ls_q <= ls;
    if (|((hs | hs_q) & (ls | ls_q))) xc <= xc + 1;
    run_hs <= hs[2] ? run_hs + 1 : 0;
    run_ls <= ls[2] ? run_ls + 1 : 0;
    if (arm == 2'h1 && hs_q[2] && !hs[2] && run_hs < min_off) min_off <= run_hs;
    if (arm == 2'h1 && ls_q[2] && !ls[2] && run_ls < min_on) min_on <= run_ls;
    if (arm == 2'h1 && ls[2] && !ls_q[2]) rises <= rises + 1;
    if (arm == 2'h2 && hs == 3'h1) seen_f <= 1'b1;
    if (arm == 2'h2 && hs == 3'h4) seen_b <= 1'b1;
  end
  // Result {hs, ls}; table holds the backward masks, forward just swaps the two
  function automatic logic [5:0] gates(input logic [2:0] c, input logic f);
    logic [5:0] r;
    case (c)
      HALL_HLL: r = 6'h21;
      HALL_HHL: r = 6'h22;
      HALL_LHL, HALL_HHH: r = 6'h0a;
      HALL_LHH: r = 6'h0c;
      HALL_LLH: r = 6'h14;
      default: r = 6'h11;
    endcase
    gates = f ? {r[2:0], r[5:3]} : r;
  endfunction : gates
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic results;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    #1000000;
    error_cnt++;
    results;
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    cyc(3);
    chk("reset_state", 8'h80, {flag_n, 1'b0, hs, ls});
    @(posedge clk) rst_n <= 1'b1;
    // Every code in both directions first, then random ones
    for (int i = 0; i < 40; i++) begin
      lf = lfsr(lf);
      @(posedge clk);
      code <= (i < 16) ? i[2:0] : lf[2:0];
      fwd <= (i < 16) ? i[3] : lf[3];
      cyc(15);
      chk("gates", {2'b10, gates(code, fwd)}, {flag_n, 1'b0, hs, ls});
    end
    $display("test decode done");
    @(posedge clk) ot <= 1'b1;
    cyc(4);
    chk("flag_early", 8'h01, {7'h0, flag_n});
    cyc(1);
    chk("flag_ot", 8'h00, {7'h0, flag_n});
    cyc(2);
    chk("gates_ot", 8'h00, {2'b00, hs, ls});
    @(posedge clk) ot <= 1'b0;
    cyc(20);
    chk("ot_clear", {2'b10, gates(code, fwd)}, {flag_n, 1'b0, hs, ls});
    for (int j = 0; j < 3; j++) begin
      @(posedge clk) oc <= 3'(1 << j);
      cyc(6);
      chk("oc_trip", 8'h00, {flag_n, 1'b0, hs, ls});
      @(posedge clk) oc <= 3'h0;
      cyc(5);
      chk("oc_hold", 8'h00, {2'b00, hs, ls});
      cyc(HOLD + 10);
      chk("oc_free", {2'b10, gates(code, fwd)}, {flag_n, 1'b0, hs, ls});
    end
    @(posedge clk) brk_n <= 1'b0;
    cyc(15);
    chk("brake", 8'hb8, {flag_n, 1'b0, hs, ls});
    @(posedge clk) oc <= 3'h2;
    cyc(6);
    chk("brake_oc", 8'h00, {flag_n, 1'b0, hs, ls});
    @(posedge clk) oc <= 3'h0;
    cyc(HOLD + 10);
    chk("brake_back", 8'hb8, {flag_n, 1'b0, hs, ls});
    @(posedge clk);
    brk_n <= 1'b1;
    code <= HALL_HLL;
    fwd <= 1'b1;
    cyc(15);
    $display("test protection done");
    @(posedge clk);
    amp_en <= 1'b1;
    arm <= 2'h1;
    cyc(400);
    @(posedge clk);
    amp_en <= 1'b0;
    arm <= 2'h2;
    chop_en <= 1'b1;
    cyc(200);
    @(posedge clk);
    chop_en <= 1'b0;
    arm <= 2'h0;
    cyc(2);
    chk("chop_count", 8'h01, {7'h0, rises >= 3});
    // Both-off lasts one cycle longer than the dead count
    chk("off_time", 8'h01, {7'h0, min_off >= OFF_T - DEAD_CYC - 1});
    chk("blanking", 8'h01, {7'h0, min_on >= 8});
    chk("volt_mode", 8'h03, {6'h0, seen_f, seen_b});
    chk("shoot_through", 8'h00, {7'h0, xc != 0});
    $display("test chop done");
    results;
  end
endmodule : tb_top
